// File: logic/icr_drive_decode.v
// floppy drive select and motor output decoding, two-drive and four-drive forms
`timescale 1ns/1ps
module icr_drive_decode
(
	input  wire       four_drive_select,
	input  wire [3:0] motor_enable,
	input  wire [1:0] drive_select,
	output reg        motor_a_out_n,
	output reg        motor_b_out_n,
	output reg        drive_select_a_out_n,
	output reg        drive_select_b_out_n
);

	always @*
	begin
		motor_a_out_n        = 1'b1;
		motor_b_out_n        = 1'b1;
		drive_select_a_out_n = 1'b1;
		drive_select_b_out_n = 1'b1;
		if (four_drive_select) // RULE10
		begin
			// selects pass straight through even with motors off
			drive_select_a_out_n = drive_select[0]; // RULE12
			drive_select_b_out_n = drive_select[1]; // RULE12
			if (motor_enable == 4'h1 || motor_enable == 4'h2 || motor_enable == 4'h4 || motor_enable == 4'h8)
			begin
				motor_a_out_n = 1'b0; // RULE12
				motor_b_out_n = 1'b0; // RULE12
			end
		end
		else if (motor_enable == 4'h1 && drive_select == 2'h0)
		begin
			motor_a_out_n        = 1'b0; // RULE11
			drive_select_a_out_n = 1'b0; // RULE11
		end
		else if (motor_enable == 4'h2 && drive_select == 2'h1)
		begin
			motor_b_out_n        = 1'b0; // RULE11
			drive_select_b_out_n = 1'b0; // RULE11
		end
	end

endmodule

// File: logic/icr_map.vh
// register offsets, field positions, reset values and divide counts of config registers three to six
`ifndef ICR_MAP_VH
`define ICR_MAP_VH

`define ICR_IDX_UART_PIN        8'h03
`define ICR_IDX_POWER_TRI       8'h04
`define ICR_IDX_ECP_THR         8'h05
`define ICR_IDX_FLOPPY          8'h06

`define ICR_RST_UART_PIN        8'h30
`define ICR_RST_POWER_TRI       8'h00
`define ICR_RST_ECP_THR         8'h00
`define ICR_RST_FLOPPY          8'h00

`define ICR_MASK_UART_PIN       8'h33
`define ICR_MASK_POWER_TRI      8'hFF
`define ICR_MASK_ECP_THR        8'h0F
`define ICR_MASK_FLOPPY         8'h78

`define ICR_BIT_SECOND_MIDI     0
`define ICR_BIT_FIRST_MIDI      1
`define ICR_BIT_ADAPTER_SEL     4
`define ICR_BIT_EPP_VERSION     5

`define ICR_BIT_PD_LOW          4
`define ICR_BIT_TRI_LOW         0

`define ICR_THR_MSB             3

`define ICR_BIT_CTRL_PD         3
`define ICR_BIT_PULLUP_DIS      4
`define ICR_BIT_FOUR_DRIVE      5
`define ICR_BIT_PWR_SEL_HIGH    6

`define ICR_DIV_NORMAL          4'hD
`define ICR_DIV_MIDI            4'hC

`endif

// File: logic/icr_regs.v
// index/data reached configuration registers three to six with the logic they steer
//
// Behaviour
// RULE1: second uart divides by 13, or 12
// RULE2: first uart divides by 13, or 12
// RULE3: shared pins: portable enables or game strobes
// RULE4: game dma override bit beats pin select
// RULE5: epp version bit, zero 1.9, one 1.7
// RULE6: power-down bits for four functions
// RULE7: tri-state bits float powered-down function outputs
// RULE8: ecp fifo threshold low nibble, reserved top
// RULE9: third power function select bit here
// RULE10: drive count bit picks two or four
// RULE11: two-drive motor and select decoding
// RULE12: four-drive encoded motor and select decoding
// RULE13: floppy input pull-ups, zero means enabled
// RULE14: floppy controller power-down bit
// RULE15: host enters mode, writes index first
// RULE16: tri-state ignored while function powered
`timescale 1ns/1ps
`include "icr_map.vh"
module icr_regs
(
	input  wire       clock,
	input  wire       resetn,
	input  wire       ext_mode_active,
	input  wire       config_index_port_wr,
	input  wire       config_data_port_wr,
	input  wire       config_data_port_rd,
	input  wire [7:0] io_wdata,
	output reg  [7:0] io_rdata,
	output reg        io_rdata_valid,
	input  wire       game_port_dma_override,
	input  wire [1:0] power_function_select_low_mid,
	input  wire       portable_floppy_enable_in,
	input  wire       portable_extension_enable_in,
	input  wire       game_port_read_in,
	input  wire       game_port_write_in,
	input  wire [3:0] motor_enable,
	input  wire [1:0] drive_select,
	output reg        first_uart_clk_tick,
	output reg        second_uart_clk_tick,
	output reg        pin41_out,
	output reg        pin39_out,
	output reg        adapter_mode_active,
	output reg        epp_version_select,
	output reg  [3:0] function_power_down,
	output reg  [3:0] function_out_enable_n,
	output reg  [3:0] ecp_fifo_threshold,
	output reg  [2:0] power_function_select,
	output reg        floppy_input_pullup_enable,
	output reg        floppy_ctrl_power_down,
	output reg        motor_a_out_n,
	output reg        motor_b_out_n,
	output reg        drive_select_a_out_n,
	output reg        drive_select_b_out_n
);

	reg  [7:0] config_index_port;
	reg  [7:0] uart_clock_pin_function_cfg;
	reg  [7:0] function_power_tristate_cfg;
	reg  [7:0] ecp_fifo_threshold_cfg;
	reg  [7:0] floppy_drive_power_cfg;
	reg  [7:0] next_rdata;
	wire       data_wr;
	wire       wr_uart_pin;
	wire       wr_power_tri;
	wire       wr_ecp_thr;
	wire       wr_floppy;
	wire [1:0] midi_divide;
	wire [1:0] uart_tick;
	wire       effective_adapter;
	wire       dec_motor_a_n;
	wire       dec_motor_b_n;
	wire       dec_select_a_n;
	wire       dec_select_b_n;

	// the port pair is only live in extended function mode; outside it accesses are dropped
	assign data_wr = config_data_port_wr & ext_mode_active; // RULE15

	// one strobe per register; an index outside three to six strobes none, so the write is lost
	assign wr_uart_pin  = data_wr & (config_index_port == `ICR_IDX_UART_PIN);
	assign wr_power_tri = data_wr & (config_index_port == `ICR_IDX_POWER_TRI);
	assign wr_ecp_thr   = data_wr & (config_index_port == `ICR_IDX_ECP_THR);
	assign wr_floppy    = data_wr & (config_index_port == `ICR_IDX_FLOPPY);

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			config_index_port <= 8'h00;
		else if (config_index_port_wr && ext_mode_active)
			config_index_port <= io_wdata; // RULE15
	end

	// reserved bits are never stored, so they read back as zero
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			uart_clock_pin_function_cfg <= `ICR_RST_UART_PIN; // RULE5
		else if (wr_uart_pin)
			uart_clock_pin_function_cfg <= io_wdata & `ICR_MASK_UART_PIN;
	end

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			function_power_tristate_cfg <= `ICR_RST_POWER_TRI;
		else if (wr_power_tri)
			function_power_tristate_cfg <= io_wdata & `ICR_MASK_POWER_TRI;
	end

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			ecp_fifo_threshold_cfg <= `ICR_RST_ECP_THR; // RULE8
		else if (wr_ecp_thr)
			ecp_fifo_threshold_cfg <= io_wdata & `ICR_MASK_ECP_THR; // RULE8
	end

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			floppy_drive_power_cfg <= `ICR_RST_FLOPPY; // RULE9
		else if (wr_floppy)
			floppy_drive_power_cfg <= io_wdata & `ICR_MASK_FLOPPY;
	end

	// read data holds until the next read, so a slow host may sample it late
	always @*
	begin
		next_rdata = 8'h00;
		case (config_index_port)
			`ICR_IDX_UART_PIN:  next_rdata = uart_clock_pin_function_cfg;
			`ICR_IDX_POWER_TRI: next_rdata = function_power_tristate_cfg;
			`ICR_IDX_ECP_THR:   next_rdata = ecp_fifo_threshold_cfg;
			`ICR_IDX_FLOPPY:    next_rdata = floppy_drive_power_cfg;
			default:            next_rdata = 8'h00;
		endcase
	end

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			io_rdata       <= 8'h00;
			io_rdata_valid <= 1'b0;
		end
		else
		begin
			io_rdata_valid <= config_data_port_rd & ext_mode_active;
			if (config_data_port_rd && ext_mode_active)
				io_rdata <= next_rdata;
		end
	end

	assign midi_divide[0] = uart_clock_pin_function_cfg[`ICR_BIT_FIRST_MIDI];
	assign midi_divide[1] = uart_clock_pin_function_cfg[`ICR_BIT_SECOND_MIDI];

	// one tick per divide period of the core clock; the uart baud logic counts these ticks
	genvar u;
	generate
		for (u = 0; u < 2; u = u + 1)
		begin : uart_div
			reg  [3:0] count;
			wire [3:0] divisor;
			assign divisor     = midi_divide[u] ? `ICR_DIV_MIDI : `ICR_DIV_NORMAL; // RULE1 RULE2
			assign uart_tick[u] = (count >= divisor - 4'h1);
			always @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					count <= 4'h0;
				else if (uart_tick[u])
					count <= 4'h0;
				else
					count <= count + 4'h1;
			end
		end
	endgenerate

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			first_uart_clk_tick  <= 1'b0;
			second_uart_clk_tick <= 1'b0;
		end
		else
		begin
			first_uart_clk_tick  <= uart_tick[0]; // RULE2
			second_uart_clk_tick <= uart_tick[1]; // RULE1
		end
	end

	// with the override set the shared pins fall back to their portable function
	assign effective_adapter = uart_clock_pin_function_cfg[`ICR_BIT_ADAPTER_SEL] & ~game_port_dma_override; // RULE4

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pin41_out           <= 1'b0;
			pin39_out           <= 1'b0;
			adapter_mode_active <= 1'b0;
		end
		else
		begin
			adapter_mode_active <= effective_adapter; // RULE4
			pin41_out           <= effective_adapter ? game_port_read_in : portable_floppy_enable_in; // RULE3
			pin39_out           <= effective_adapter ? game_port_write_in : portable_extension_enable_in; // RULE3
		end
	end

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			epp_version_select <= 1'b1;
		else
			epp_version_select <= uart_clock_pin_function_cfg[`ICR_BIT_EPP_VERSION]; // RULE5
	end

	// index 3 parallel, 2 game, 1 first uart, 0 second uart
	genvar f;
	generate
		for (f = 0; f < 4; f = f + 1)
		begin : func_pwr
			wire pd;
			wire tri_en;
			assign pd     = function_power_tristate_cfg[`ICR_BIT_PD_LOW + f]; // RULE6
			assign tri_en = function_power_tristate_cfg[`ICR_BIT_TRI_LOW + f];
			always @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					function_power_down[f]   <= 1'b0;
					function_out_enable_n[f] <= 1'b0;
				end
				else
				begin
					function_power_down[f]   <= pd; // RULE6
					// a powered function always drives, whatever its tri-state bit says
					function_out_enable_n[f] <= pd & tri_en; // RULE7 RULE16
				end
			end
		end
	endgenerate

	icr_drive_decode drive_dec
	(
		.four_drive_select    (floppy_drive_power_cfg[`ICR_BIT_FOUR_DRIVE]),
		.motor_enable         (motor_enable),
		.drive_select         (drive_select),
		.motor_a_out_n        (dec_motor_a_n),
		.motor_b_out_n        (dec_motor_b_n),
		.drive_select_a_out_n (dec_select_a_n),
		.drive_select_b_out_n (dec_select_b_n)
	);

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ecp_fifo_threshold         <= 4'h0;
			power_function_select      <= 3'h0;
		end
		else
		begin
			ecp_fifo_threshold         <= ecp_fifo_threshold_cfg[`ICR_THR_MSB:0]; // RULE8
			power_function_select      <= {floppy_drive_power_cfg[`ICR_BIT_PWR_SEL_HIGH],
			                               power_function_select_low_mid}; // RULE9
		end
	end

	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			floppy_input_pullup_enable <= 1'b1;
			floppy_ctrl_power_down     <= 1'b0;
		end
		else
		begin
			floppy_input_pullup_enable <= ~floppy_drive_power_cfg[`ICR_BIT_PULLUP_DIS]; // RULE13
			floppy_ctrl_power_down     <= floppy_drive_power_cfg[`ICR_BIT_CTRL_PD]; // RULE14
		end
	end

	// registered so decode hazards never reach the drive cable
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			motor_a_out_n        <= 1'b1;
			motor_b_out_n        <= 1'b1;
			drive_select_a_out_n <= 1'b1;
			drive_select_b_out_n <= 1'b1;
		end
		else
		begin
			motor_a_out_n        <= dec_motor_a_n; // RULE11 RULE12
			motor_b_out_n        <= dec_motor_b_n; // RULE11 RULE12
			drive_select_a_out_n <= dec_select_a_n; // RULE11 RULE12
			drive_select_b_out_n <= dec_select_b_n; // RULE11 RULE12
		end
	end

endmodule

// File: tb/icr_host_model.sv
// host side model driving the index and data ports
`timescale 1ns/1ps
module icr_host_model
(
	input  wire       clock,
	output reg        ext_mode_active,
	output reg        index_wr,
	output reg        data_wr,
	output reg        data_rd,
	output reg  [7:0] wdata,
	input  wire [7:0] rdata,
	input  wire       valid
);
	initial
	begin
		ext_mode_active = 1'b1;
		index_wr = 1'b0;
		data_wr = 1'b0;
		data_rd = 1'b0;
		wdata = 8'h00;
	end
	// index always first, data access on the following cycle
	task wr(input [7:0] idx, input [7:0] val);
		@(negedge clock) index_wr = 1'b1; wdata = idx;
		@(negedge clock) index_wr = 1'b0; data_wr = 1'b1; wdata = val;
		@(negedge clock) data_wr = 1'b0;
	endtask
	// a missing valid pulse turns the result unknown so it cannot match
	task rd(input [7:0] idx, output [7:0] val);
		@(negedge clock) index_wr = 1'b1; wdata = idx;
		@(negedge clock) index_wr = 1'b0; data_rd = 1'b1;
		@(negedge clock) data_rd = 1'b0;
		val = (valid === 1'b1) ? rdata : 8'hXX;
	endtask
	// extended function mode is left and re-entered only between accesses
	task set_mode(input bit on);
		@(negedge clock) ext_mode_active = on;
	endtask
endmodule

// File: tb/icr_regs_monitor.sv
// assertion checker on the config register block ports
`timescale 1ns/1ps
module icr_regs_monitor
(
	input wire       clock,
	input wire       resetn,
	input wire       ext_mode_active,
	input wire       config_index_port_wr,
	input wire       config_data_port_wr,
	input wire       config_data_port_rd,
	input wire [7:0] io_wdata,
	input wire       io_rdata_valid,
	input wire       game_port_dma_override,
	input wire [1:0] power_function_select_low_mid,
	input wire       game_port_read_in,
	input wire       first_uart_clk_tick,
	input wire       second_uart_clk_tick,
	input wire       pin41_out,
	input wire       adapter_mode_active,
	input wire       epp_version_select,
	input wire [3:0] function_power_down,
	input wire [3:0] function_out_enable_n,
	input wire [3:0] ecp_fifo_threshold,
	input wire [2:0] power_function_select
);
	// own copy of the index so writes can be tied to their register
	reg  [7:0] index;
	reg  [7:0] shadow;
	wire       wr_any;
	wire       rd_ok;
	assign wr_any = ext_mode_active && config_data_port_wr;
	assign rd_ok  = ext_mode_active && config_data_port_rd;
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			index  <= 8'h00;
			shadow <= 8'h00;
		end
		else
		begin
			if (ext_mode_active && config_index_port_wr)
				index <= io_wdata;
			if (wr_any)
				shadow <= io_wdata;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_read_answer: assert property (rd_ok |=> io_rdata_valid)
		else $error("read not answered");
	chk_read_quiet: assert property (!rd_ok |=> !io_rdata_valid)
		else $error("stray read valid");
	// a second write right behind would move the shadow copy before the check, so it is excluded
	chk_epp_write: assert property (wr_any && index == 8'h03 ##1 !wr_any |=> epp_version_select == shadow[5])
		else $error("epp version not taken");
	chk_thr_write: assert property (wr_any && index == 8'h05 ##1 !wr_any |=> ecp_fifo_threshold == shadow[3:0])
		else $error("threshold not taken");
	chk_dma_wins: assert property (game_port_dma_override |=> !adapter_mode_active)
		else $error("override ignored");
	chk_pin_game: assert property (adapter_mode_active && $past(adapter_mode_active) |-> pin41_out == $past(game_port_read_in))
		else $error("pin not game strobe");
	chk_tri_gate: assert property ((function_out_enable_n & ~function_power_down) == 4'h0)
		else $error("powered function floated");
	chk_pfs_low: assert property ($past(resetn) |->
		power_function_select[1:0] == $past(power_function_select_low_mid))
		else $error("select low bits wrong");
	chk_first_tick: assert property (first_uart_clk_tick |-> ##[12:13] first_uart_clk_tick)
		else $error("first uart tick spacing");
	chk_second_tick: assert property (second_uart_clk_tick |-> ##[12:13] second_uart_clk_tick)
		else $error("second uart tick spacing");
endmodule
bind icr_regs icr_regs_monitor mon_u (.clock(clock), .resetn(resetn), .ext_mode_active(ext_mode_active),
	.config_index_port_wr(config_index_port_wr), .config_data_port_wr(config_data_port_wr),
	.config_data_port_rd(config_data_port_rd), .io_wdata(io_wdata), .io_rdata_valid(io_rdata_valid),
	.game_port_dma_override(game_port_dma_override), .power_function_select_low_mid(power_function_select_low_mid),
	.game_port_read_in(game_port_read_in), .first_uart_clk_tick(first_uart_clk_tick),
	.second_uart_clk_tick(second_uart_clk_tick), .pin41_out(pin41_out), .adapter_mode_active(adapter_mode_active),
	.epp_version_select(epp_version_select), .function_power_down(function_power_down),
	.function_out_enable_n(function_out_enable_n), .ecp_fifo_threshold(ecp_fifo_threshold),
	.power_function_select(power_function_select));

// File: tb/icr_regs_tb.sv
// self-checking bench for config registers three to six
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("Error %0t: got %h want %h", $time, a, e); end end
module icr_regs_tb;
	reg        clock = 1'b0;
	reg        resetn = 1'b0;
	reg        override = 1'b0;
	reg  [1:0] pfs_lm = 2'h2;
	reg  [3:0] pin_src = 4'h6;
	reg  [3:0] me = 4'h0;
	reg  [1:0] ds = 2'h0;
	wire       ext, iw, dw, dr, valid, t1, t2, p41, p39, adapter, epp, pull, cpd, mo_a, mo_b, ds_a, ds_b;
	wire [7:0] wdata, rdata;
	wire [3:0] pd, oen, thr;
	wire [2:0] pfs;
	reg  [7:0] v;
	int        n_errors = 0;
	int        checks = 0;
	int        i;
	// {motor enables, drive select, expected mob moa dsb dsa}: two-drive then four-drive
	reg  [9:0] tbl [0:9] = '{10'h00F, 10'h04A, 10'h095, 10'h11F, 10'h23F, 10'h00C, 10'h040, 10'h091, 10'h122, 10'h233};
	always #25 clock = ~clock;
	icr_host_model host_u (.clock(clock), .ext_mode_active(ext), .index_wr(iw), .data_wr(dw), .data_rd(dr),
		.wdata(wdata), .rdata(rdata), .valid(valid));
	icr_regs dut_u (.clock(clock), .resetn(resetn), .ext_mode_active(ext), .config_index_port_wr(iw),
		.config_data_port_wr(dw), .config_data_port_rd(dr), .io_wdata(wdata), .io_rdata(rdata),
		.io_rdata_valid(valid), .game_port_dma_override(override), .power_function_select_low_mid(pfs_lm),
		.portable_floppy_enable_in(pin_src[0]), .portable_extension_enable_in(pin_src[1]),
		.game_port_read_in(pin_src[2]), .game_port_write_in(pin_src[3]), .motor_enable(me), .drive_select(ds),
		.first_uart_clk_tick(t1), .second_uart_clk_tick(t2), .pin41_out(p41), .pin39_out(p39),
		.adapter_mode_active(adapter), .epp_version_select(epp), .function_power_down(pd),
		.function_out_enable_n(oen), .ecp_fifo_threshold(thr), .power_function_select(pfs),
		.floppy_input_pullup_enable(pull), .floppy_ctrl_power_down(cpd), .motor_a_out_n(mo_a),
		.motor_b_out_n(mo_b), .drive_select_a_out_n(ds_a), .drive_select_b_out_n(ds_b));
	task wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask
	task end_of_test;
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// cycles from one tick to the next, bounded so a dead divider ends the run
	task tick_gap(input bit second, input int want);
		int n;
		n = 0;
		while ((second ? t2 : t1) !== 1'b1 && n < 40) begin @(negedge clock); n++; end
		n = 1;
		@(negedge clock);
		while ((second ? t2 : t1) !== 1'b1 && n < 40) begin @(negedge clock); n++; end
		`CHK(n, want)
		if (n >= 40)
			end_of_test;
	endtask
	task drv(input [9:0] t);
		me = t[9:6];
		ds = t[5:4];
		wait_n(3);
		`CHK({mo_b, mo_a, ds_b, ds_a}, t[3:0])
	endtask
	initial
	begin
		wait_n(10);
		resetn = 1'b1;
		wait_n(1);
		`CHK({epp, pull, cpd, pd, oen, thr}, 15'h6000)
		for (i = 3; i < 7; i++) begin host_u.rd(i[7:0], v); `CHK(v, (i == 3) ? 8'h30 : 8'h00) end
		tick_gap(1'b0, 13);
		tick_gap(1'b1, 13);
		host_u.wr(8'h03, 8'hFF);
		host_u.rd(8'h03, v); `CHK(v, 8'h33)
		wait_n(2); `CHK({adapter, epp, p41, p39}, 4'hE)
		override = 1'b1;
		wait_n(3); `CHK({adapter, p41, p39}, 3'h1)
		override = 1'b0;
		tick_gap(1'b0, 12);
		tick_gap(1'b1, 12);
		host_u.wr(8'h03, 8'h00);
		wait_n(2); `CHK({adapter, epp, p41, p39}, 4'h1)
		host_u.wr(8'h04, 8'h81);
		wait_n(2); `CHK({pd, oen}, 8'h80)
		host_u.wr(8'h04, 8'hFF);
		wait_n(2); `CHK({pd, oen}, 8'hFF)
		host_u.wr(8'h04, 8'h0F);
		wait_n(2); `CHK({pd, oen}, 8'h00)
		host_u.wr(8'h05, 8'hFF);
		host_u.rd(8'h05, v); `CHK({v, thr}, 12'h0FF)
		host_u.wr(8'h06, 8'hFF);
		host_u.rd(8'h06, v); `CHK(v, 8'h78)
		`CHK({pfs, pull, cpd}, {1'b1, pfs_lm, 2'h1})
		for (i = 5; i < 10; i++) drv(tbl[i]);
		host_u.wr(8'h06, 8'h00);
		for (i = 0; i < 5; i++) drv(tbl[i]);
		// outside extended mode the strobes must leave every register alone
		host_u.set_mode(1'b0);
		host_u.wr(8'h05, 8'h30);
		host_u.set_mode(1'b1);
		host_u.rd(8'h05, v); `CHK(v, 8'h0F)
		host_u.rd(8'h06, v); `CHK(v, 8'h00)
		host_u.rd(8'h07, v); `CHK(v, 8'h00)
		end_of_test;
	end
endmodule
